// >>> include/phy_status_defs.vh
// Offsets, bit positions, reset values and identifier parameters
// for the PHY status and identifier register bank.
`ifndef PHY_STATUS_DEFS_VH
`define PHY_STATUS_DEFS_VH

// Register addresses on the management interface
`define REG_BASIC_STATUS 5'h01
`define REG_ID_HIGH 5'h02
`define REG_ID_LOW 5'h03

// Status bit positions
`define ST_T4 15
`define ST_TX_FD 14
`define ST_TX_HD 13
`define ST_10_FD 12
`define ST_10_HD 11
`define ST_PREAMBLE_SUP 6
`define ST_AN_DONE 5
`define ST_REMOTE_FAULT 4
`define ST_AN_ABLE 3
`define ST_LINK 2
`define ST_JABBER 1
`define ST_EXT_CAP 0

// Fixed status bits: capabilities, preamble suppression, extended set
`define STATUS_FIXED 16'h7849
// Reset values of latched flags
`define LATCH_RESET 1'b0
`define LINK_RESET 1'b0

// Identifier values, arbitrary neutral defaults
`define ORG_CODE_DEFAULT 24'h123456
`define MODEL_NUMBER_DEFAULT 6'h15
`define REVISION_DEFAULT 4'h2

`endif

// >>> rtl/phy_flag_latch.v
// Sticky flag: set by an event, cleared by a read strobe.
// Assumes the event is already synchronous to CLK_SYS.
`timescale 1ns/100ps
module phy_flag_latch (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire set_evt,
  input wire clr_evt,
  // State
  output reg flag_ff
);
  // Set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (clr_evt) begin
      flag_ff <= 1'b0;
    end
  end
endmodule // phy_flag_latch

// >>> rtl/phy_link_latch.v
// Latching-low link indicator: any failure clears it until read.
// Assumes link input is synchronous to CLK_SYS.
`timescale 1ns/100ps
module phy_link_latch (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire link_up,
  input wire rd_evt,
  // State
  output reg link_ff
);
  // A failure wins over a read; a read reloads the live level
  always @(posedge clk) begin
    if (rst) begin
      link_ff <= 1'b0;
    end else if (!link_up) begin
      link_ff <= 1'b0;
    end else if (rd_evt) begin
      link_ff <= 1'b1;
    end
  end
endmodule // phy_link_latch

// >>> rtl/phy_status_regs.v
// PHY basic status and identifier registers, read through the
// management frame engine (not included here).
// Assumes status inputs arrive from pins or other clocks and are synchronised here;
// management read strobe and address are on CLK_SYS.
//
// Behaviour
// - Status bit 15 always reads 0: four-pair 100M not supported.
// - Status bits 14..11 always read 1: 100M and 10M, full and half duplex.
// - Status bits 10..7 read zero; writes ignored.
// - Status bit 6 reads 1; preamble-less management frames accepted.
// - Status bit 5 shows auto-negotiation complete; resets to 0.
// - Bit 4 sets on partner remote fault; cleared by status read or reset.
// - Status bit 3 always reads 1: auto-negotiation able.
// - Bit 2 shows link; any failure clears it until status read.
// - Status bit 0 always reads 1: extended registers present.
// - First identifier holds organization code bits 3..18 on bits 15..0.
// - Second identifier bits 15..10 hold organization code bits 19..24.
// - Second identifier bits 9..4 hold model number, MSB at bit 9.
// - Second identifier bits 3..0 hold the model revision.
`timescale 1ns/100ps
`include "phy_status_defs.vh"
module phy_status_regs #(
  // Identifier contents, values arbitrary
  parameter [23:0] ORG_CODE = `ORG_CODE_DEFAULT,
  parameter [5:0] MODEL_NUMBER = `MODEL_NUMBER_DEFAULT,
  parameter [3:0] REVISION = `REVISION_DEFAULT
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire SYS_RST,
  // Management read and write access
  input wire MGMT_RD,
  input wire [4:0] MGMT_ADDR,
  input wire MGMT_WR,
  input wire [15:0] MGMT_WDATA,
  output reg [15:0] MGMT_RDATA,
  output reg MGMT_HIT,
  output wire PREAMBLE_SUPPRESS_OK,
  // PHY status inputs, asynchronous
  input wire AN_COMPLETE,
  input wire PARTNER_REMOTE_FAULT,
  input wire LINK_UP,
  input wire JABBER,
  input wire SPEED_100
);
  // Two-stage synchronisers for the five status inputs
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {SPEED_100, JABBER, LINK_UP, PARTNER_REMOTE_FAULT, AN_COMPLETE};
      sync2_ff <= sync1_ff;
    end
  end

  wire an_done = sync2_ff[0];
  wire rfault = sync2_ff[1];
  wire link_s = sync2_ff[2];
  wire jab_s = sync2_ff[3];
  wire speed_s = sync2_ff[4];

  // Remote fault edge detect, so a held fault does not re-set after read
  reg rfault_d_ff;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rfault_d_ff <= `LATCH_RESET;
    end else begin
      rfault_d_ff <= rfault;
    end
  end

  wire status_rd = MGMT_RD && (MGMT_ADDR == `REG_BASIC_STATUS);
  wire rf_ff;
  wire jab_ff;
  wire link_ff;

  // Remote fault latch
  phy_flag_latch u_rfault (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .set_evt(rfault && !rfault_d_ff),
    .clr_evt(status_rd),
    .flag_ff(rf_ff)
  );

  // Jabber latch, qualified by 10 Mb/s operation
  phy_flag_latch u_jabber (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .set_evt(jab_s && !speed_s),
    .clr_evt(status_rd),
    .flag_ff(jab_ff)
  );

  // Link latch
  phy_link_latch u_link (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .link_up(link_s),
    .rd_evt(status_rd),
    .link_ff(link_ff)
  );

  // Assembled status word; fixed bits from the constant, reserved zero
  wire [15:0] status_word;
  assign status_word = `STATUS_FIXED
    | ({15'h0000, an_done} << `ST_AN_DONE)
    | ({15'h0000, rf_ff} << `ST_REMOTE_FAULT)
    | ({15'h0000, link_ff} << `ST_LINK)
    | ({15'h0000, jab_ff} << `ST_JABBER);

  // Identifier words; code bit 1 is ORG_CODE[23], so the top two bits are dropped
  wire [15:0] id_high = ORG_CODE[21:6];
  wire [15:0] id_low = {ORG_CODE[5:0], MODEL_NUMBER, REVISION};

  // Read data captured from current flag values before the clear lands
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      MGMT_RDATA <= 16'h0000;
      MGMT_HIT <= 1'b0;
    end else if (MGMT_RD) begin
      if (MGMT_ADDR == `REG_BASIC_STATUS) begin
        MGMT_RDATA <= status_word;
        MGMT_HIT <= 1'b1;
      end else if (MGMT_ADDR == `REG_ID_HIGH) begin
        MGMT_RDATA <= id_high;
        MGMT_HIT <= 1'b1;
      end else if (MGMT_ADDR == `REG_ID_LOW) begin
        MGMT_RDATA <= id_low;
        MGMT_HIT <= 1'b1;
      end else begin
        MGMT_RDATA <= 16'h0000;
        MGMT_HIT <= 1'b0;
      end
    end
  end

  // Writes hit only read-only bits and are ignored
  assign PREAMBLE_SUPPRESS_OK = status_word[`ST_PREAMBLE_SUP];
endmodule // phy_status_regs

// >>> test/mgmt_station_model.sv
// Management station model: one read per call.
// Drives its strobe just after the rising edge.
`timescale 1ns/100ps
module mgmt_station_model (
  // Clock and access
  input wire clk,
  output reg rd = 1'b0,
  output reg [4:0] addr = 5'h00
);
  // One-cycle strobe, then a changed address
  task access(input [4:0] a);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
    end
  endtask
endmodule // mgmt_station_model

// >>> test/phy_status_props.sv
// Port checker for the status bank.
// Bound into phy_status_regs below.
`timescale 1ns/100ps
`include "phy_status_defs.vh"
module phy_status_props (
  // Watched ports
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire MGMT_RD,
  input wire [4:0] MGMT_ADDR,
  input wire [15:0] MGMT_RDATA,
  input wire MGMT_HIT,
  input wire PREAMBLE_SUPPRESS_OK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Reads by address
  wire rs = MGMT_RD && MGMT_ADDR == 5'h01;
  wire rm = MGMT_RD && (MGMT_ADDR == 5'h00 || MGMT_ADDR > 5'h03);
  // Identifier words expected from the default constants
  localparam [23:0] ORG_CHK = `ORG_CODE_DEFAULT;
  localparam [15:0] ID_HIGH_CHK = ORG_CHK[21:6];
  localparam [15:0] ID_LOW_CHK = {ORG_CHK[5:0], `MODEL_NUMBER_DEFAULT, `REVISION_DEFAULT};
  id_high_a: assert property (MGMT_RD && MGMT_ADDR == 5'h02 |=> MGMT_RDATA == ID_HIGH_CHK) else $error("idh");
  id_low_a: assert property (MGMT_RD && MGMT_ADDR == 5'h03 |=> MGMT_RDATA == ID_LOW_CHK) else $error("idl");
  no_t4_a: assert property (rs |=> !MGMT_RDATA[15]) else $error("t4");
  caps_on_a: assert property (rs |=> MGMT_RDATA[14:11] == 4'hF) else $error("caps");
  resv_zero_a: assert property (rs |=> MGMT_RDATA[10:7] == 4'h0) else $error("resv");
  pre_ok_a: assert property (rs |=> MGMT_RDATA[6] && PREAMBLE_SUPPRESS_OK) else $error("pre");
  able_bits_a: assert property (rs |=> MGMT_RDATA[3] && MGMT_RDATA[0]) else $error("able");
  miss_zero_a: assert property (rm |=> MGMT_RDATA == 16'h0000 && !MGMT_HIT) else $error("miss");
  hit_on_a: assert property (MGMT_RD && !rm |=> MGMT_HIT) else $error("hit");
  data_hold_a: assert property (!MGMT_RD |=> $stable(MGMT_RDATA)) else $error("hold");
  // Main scenarios
  cover property (rs ##1 MGMT_RDATA[2]);
  cover property (rs ##1 MGMT_RDATA[4]);
  cover property (rs ##1 MGMT_RDATA[1]);
endmodule // phy_status_props
bind phy_status_regs phy_status_props u_props (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .MGMT_RD(MGMT_RD),
  .MGMT_ADDR(MGMT_ADDR), .MGMT_RDATA(MGMT_RDATA), .MGMT_HIT(MGMT_HIT), .PREAMBLE_SUPPRESS_OK(PREAMBLE_SUPPRESS_OK));

// >>> test/phy_status_regs_test.sv
// Bench for the status bank, reads by the station model.
// Assumes the design default identifier values.
`timescale 1ns/100ps
`include "phy_status_defs.vh"
module phy_status_regs_test;
  localparam [23:0] ORG = `ORG_CODE_DEFAULT;
  reg CLK_SYS, SYS_RST;
  reg [4:0] lvl = 5'h00;
  reg wr = 1'b0;
  reg [15:0] wd = 16'h0000;
  reg rd_d = 1'b0;
  reg [16:0] q [$];
  integer error_cnt = 0, checks_done = 0, cyc = 0, i, seed = 32'h48885FB9;
  wire rd, hit;
  wire [4:0] addr;
  wire [15:0] rdata;
  // Steps: line level, expected {an, fault, link, jabber}, address
  reg [19:0] tab [0:14] = '{20'h00001, 20'h00002, 20'h00003, 20'h0001F, 20'h05801, 20'h05A01, 20'h01000,
    20'h05801, 20'h07E01, 20'h07A01, 20'h0D000, 20'h05B01, 20'h05A01, 20'h1D000, 20'h15A01};
  mgmt_station_model st (.clk(CLK_SYS), .rd(rd), .addr(addr));
  phy_status_regs dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .MGMT_RD(rd), .MGMT_ADDR(addr), .MGMT_WR(wr),
    .MGMT_WDATA(wd), .MGMT_RDATA(rdata), .MGMT_HIT(hit), .PREAMBLE_SUPPRESS_OK(), .AN_COMPLETE(lvl[0]),
    .PARTNER_REMOTE_FAULT(lvl[1]), .LINK_UP(lvl[2]), .JABBER(lvl[3]), .SPEED_100(lvl[4]));
  task check(input [16:0] seen, input [16:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Queue the expected answer, then read
  task rx(input [4:0] a, input [3:0] f);
    reg [16:0] e;
    begin
      e = 17'h00000;
      if (a == 5'h01) e = {1'b1, 16'h7849 | {10'h000, f[3:2], 1'b0, f[1:0], 1'b0}};
      if (a == 5'h02) e = {1'b1, ORG[21:6]};
      if (a == 5'h03) e = {1'b1, ORG[5:0], `MODEL_NUMBER_DEFAULT, `REVISION_DEFAULT};
      q.push_back(e);
      st.access(a);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  // Result monitor and cycle ceiling
  always @(posedge CLK_SYS) begin
    if (rd_d) check({hit, rdata}, q.pop_front());
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  // Reset, latch steps, random reads
  initial begin
    SYS_RST = 1'b1;
    repeat (8) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    for (i = 0; i < 15; i = i + 1) begin
      lvl <= tab[i][16:12];
      repeat (4) @(posedge CLK_SYS);
      rx(tab[i][4:0], tab[i][11:8]);
    end
    $display("Latch test done");
    for (i = 0; i < 8; i = i + 1) begin
      wr <= 1'($random(seed));
      wd <= 16'($random(seed));
      rx(5'($random(seed)), 4'hA);
    end
    $display("Random test done");
    // Fault and jabber latched at 10 Mb/s, then cleared by a mid-run reset
    lvl <= 5'h0B;
    repeat (4) @(posedge CLK_SYS);
    SYS_RST <= 1'b1;
    lvl <= 5'h00;
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    rx(5'h01, 4'h0);
    $display("Reset test done");
    repeat (3) @(posedge CLK_SYS);
    test_done;
  end
endmodule // phy_status_regs_test
